// ---- src/sacc_params.svh ----
// Contract
// - Converter runs only while enable bit set
// - Each conversion result lands in result bytes
// - Justify bit selects right or left alignment
// - Eight-bit mode fills high byte only
// - Eight-bit conversion is two clocks shorter
// - SAR clock divided down from system clock
// - Six selectable conversion start sources
// - Busy write starts on-demand software conversion
// - Busy stays high through whole conversion
// - Busy falling edge sets complete flag, interrupt
// - Timer 2/3 overflow byte follows mode
// - Delayed tracking adds three SAR clocks
// - Without delayed tracking conversion starts immediately
// - Internal triggers track whenever converter idle
// - Strobe trigger tracking follows strobe level; with delayed tracking the code tracks whenever not converting
// - Divider field is sysclk/sarclk minus one
// - Conversion takes 13 or 11 SAR clocks
`ifndef SACC_PARAMS_SVH
`define SACC_PARAMS_SVH

// ==========================================================
// Register addresses
`define SACC_ADDR_CTRL  8'he8
`define SACC_ADDR_CFG   8'hbc
`define SACC_ADDR_RESHI 8'hbe
`define SACC_ADDR_RESLO 8'hbd

// ==========================================================
// Control register fields
`define SACC_CTRL_EN    7
`define SACC_CTRL_DTRK  6
`define SACC_CTRL_DONE  5
`define SACC_CTRL_BUSY  4
`define SACC_CTRL_SELHI 2
`define SACC_CTRL_SELLO 0
`define SACC_CTRL_RST   8'h00
`define SACC_SEL_RST    3'h0

// ==========================================================
// Configuration register fields
`define SACC_CFG_DIVHI  7
`define SACC_CFG_DIVLO  3
`define SACC_CFG_JUST   2
`define SACC_CFG_EIGHT  1
`define SACC_CFG_GAIN   0
`define SACC_CFG_RST    8'hf9

// ==========================================================
// Trigger select codes
`define SACC_TRIG_SW    3'h0
`define SACC_TRIG_TMR0  3'h1
`define SACC_TRIG_TMR2  3'h2
`define SACC_TRIG_TMR1  3'h3
`define SACC_TRIG_EXT   3'h4
`define SACC_TRIG_TMR3  3'h5

// ==========================================================
// Conversion timing in SAR clocks
`define SACC_CLKS_TEN   4'hd
`define SACC_CLKS_EIGHT 4'hb
`define SACC_FIRST_DEC  4'h2
`define SACC_IDX_BASE   4'hb
`define SACC_LOW_TEN    4'h0
`define SACC_LOW_EIGHT  4'h2
`define SACC_DLY_CLKS   2'h3
`define SACC_DLY_LAST   2'h2
`define SACC_CODE_START 10'h200

`endif

// ---- src/sacc_pkg.sv ----
// ==========================================================
// Shared types
package sacc_pkg;
  // Control sequencer states
  typedef enum logic [1:0] {
    SACC_IDLE,
    SACC_DELAY,
    SACC_CONV
  } sacc_state_t;
endpackage

// ---- src/sacc_sar_seq.sv ----
`timescale 1ns/1ps
`include "sacc_params.svh"
// ==========================================================
// Successive approximation bit sequencer
module sacc_sar_seq (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       sar_tick,
  input  wire logic       eight_bit,
  input  wire logic       cmp_in,
  output logic [9:0]      trial_code,
  output logic [9:0]      result,
  output logic            done
);
  logic       active;     // Conversion in flight
  logic [3:0] clk_cnt;    // SAR clocks seen so far
  wire  [3:0] last_clk;   // Index of final SAR clock
  wire  [3:0] low_idx;    // Lowest bit resolved
  wire        dec_valid;  // This tick decides a bit
  wire  [3:0] dec_idx;    // Bit decided on this tick
  wire        step;       // Active SAR clock edge
  wire  [9:0] code_start = `SACC_CODE_START; // First trial, MSB only

  // Eight-bit mode stops two clocks early
  assign last_clk  = eight_bit ? (`SACC_CLKS_EIGHT - 4'h1)
                               : (`SACC_CLKS_TEN - 4'h1);
  assign low_idx   = eight_bit ? `SACC_LOW_EIGHT : `SACC_LOW_TEN;
  assign step      = active & sar_tick & ~abort;
  assign dec_valid = (clk_cnt >= `SACC_FIRST_DEC) & (clk_cnt < last_clk);
  assign dec_idx   = `SACC_IDX_BASE - clk_cnt;

  // ==========================================================
  // Clock counter and completion
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      active  <= 1'b0;
      clk_cnt <= 4'h0;
      done    <= 1'b0;
      result  <= 10'h000;
    end else begin
      done <= 1'b0;
      // Abort wins so a shutdown never reports data
      if (abort) begin
        active <= 1'b0;
      end else if (start) begin
        active  <= 1'b1;
        clk_cnt <= 4'h0;
      end else if (step) begin
        clk_cnt <= clk_cnt + 4'h1;
        if (clk_cnt == last_clk) begin
          active <= 1'b0;
          done   <= 1'b1;
          result <= trial_code;
        end
      end
    end
  end

  // ==========================================================
  // One flop per trial bit: keep or drop, then try next lower
  for (genvar b = 0; b < 10; b++) begin : g_bit
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        trial_code[b] <= 1'b0;
      end else if (start) begin
        trial_code[b] <= code_start[b];
      end else if (step && dec_valid) begin
        if (dec_idx == 4'(b)) begin
          trial_code[b] <= cmp_in;
        end else if ((dec_idx == 4'(b + 1)) && (4'(b) >= low_idx)) begin
          trial_code[b] <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- src/sacc_conv_ctrl.sv ----
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "sacc_params.svh"
// ==========================================================
// Conversion control for the 10-bit SAR converter
module sacc_conv_ctrl (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       tmr0_ovf,
  input  wire logic       tmr1_ovf,
  input  wire logic       tmr2_lo_ovf,
  input  wire logic       tmr2_hi_ovf,
  input  wire logic       tmr2_split,
  input  wire logic       tmr3_lo_ovf,
  input  wire logic       tmr3_hi_ovf,
  input  wire logic       tmr3_split,
  input  wire logic       external_convert_strobe,
  input  wire logic       irq_enable,
  input  wire logic       cmp_in,
  output logic            conv_irq,
  output logic            sar_power_on,
  output logic            sar_track,
  output logic            sar_clk_tick,
  output logic      [9:0] sar_trial_code
);

  // ==========================================================
  // Software visible state
  logic       converter_enable_bit;     // Whole converter on
  logic       delayed_tracking_bit;     // Three-clock track delay
  logic       conversion_complete_flag; // Sticky completion
  logic [2:0] trigger_select_field;     // Start source
  logic [4:0] sar_clock_divider;        // Divide minus one
  logic       justify_select_bit;       // 1 means left aligned
  logic       eight_bit_mode_bit;       // Eight-bit conversions
  logic       gain_bit;                 // Kept for readback only
  logic [7:0] result_high_byte;         // Result, upper byte
  logic [7:0] result_low_byte;          // Result, lower byte

  // ==========================================================
  // Internal state
  sacc_pkg::sacc_state_t state;         // Sequencer state
  sacc_pkg::sacc_state_t next_state;    // Its next value
  logic [4:0] div_cnt;                  // SAR clock divider count
  logic [1:0] dly_cnt;                  // Delay clocks elapsed
  logic       strb_s1;                  // Strobe sync stage one
  logic       strb_s2;                  // Strobe sync stage two
  logic       strb_s3;                  // Previous synced level
  logic       next_track;               // Next tracking level
  logic [9:0] seq_result;               // Raw converted code
  logic       seq_done;                 // Sequencer finished

  // ==========================================================
  // Address decode
  wire wr_ctrl  = reg_wr & (reg_addr == `SACC_ADDR_CTRL);
  wire wr_cfg   = reg_wr & (reg_addr == `SACC_ADDR_CFG);
  wire wr_reshi = reg_wr & (reg_addr == `SACC_ADDR_RESHI);
  wire wr_reslo = reg_wr & (reg_addr == `SACC_ADDR_RESLO);

  // Busy reads one from trigger to completion
  wire busy = (state != sacc_pkg::SACC_IDLE);
  wire idle = (state == sacc_pkg::SACC_IDLE);

  // ==========================================================
  // Trigger selection
  wire sel_ext  = (trigger_select_field == `SACC_TRIG_EXT);
  // Software start uses the select value already stored
  wire sw_go    = wr_ctrl & reg_wdata[`SACC_CTRL_BUSY]
                & (trigger_select_field == `SACC_TRIG_SW);
  // Split timers overflow from the low byte
  wire tmr2_evt = tmr2_split ? tmr2_lo_ovf : tmr2_hi_ovf;
  wire tmr3_evt = tmr3_split ? tmr3_lo_ovf : tmr3_hi_ovf;
  wire strb_rise = strb_s2 & ~strb_s3;
  // Reserved codes select nothing
  wire trig_evt =
    (trigger_select_field == `SACC_TRIG_SW)   ? sw_go     :
    (trigger_select_field == `SACC_TRIG_TMR0) ? tmr0_ovf  :
    (trigger_select_field == `SACC_TRIG_TMR2) ? tmr2_evt  :
    (trigger_select_field == `SACC_TRIG_TMR1) ? tmr1_ovf  :
    (trigger_select_field == `SACC_TRIG_EXT)  ? strb_rise :
    (trigger_select_field == `SACC_TRIG_TMR3) ? tmr3_evt  :
    1'b0;
  // Triggers during a conversion are dropped
  wire trig_fire = converter_enable_bit & idle & trig_evt;

  // ==========================================================
  // SAR clock and start timing
  // No stray strobe to the core once the last bit is in
  wire run      = converter_enable_bit & busy & ~seq_done;
  wire sar_tick = run & (div_cnt == sar_clock_divider);
  wire dly_done = (state == sacc_pkg::SACC_DELAY) & sar_tick
                & (dly_cnt == `SACC_DLY_LAST);
  wire seq_start = (trig_fire & ~delayed_tracking_bit)
                 | dly_done;
  wire conv_ok  = seq_done & converter_enable_bit;

  // ==========================================================
  // Result formatting
  wire [7:0] fmt_hi = eight_bit_mode_bit ? seq_result[9:2] :
                      justify_select_bit ? seq_result[9:2] :
                      {6'h00, seq_result[9:8]};
  wire [7:0] fmt_lo = eight_bit_mode_bit ? 8'h00 :
                      justify_select_bit ? {seq_result[1:0], 6'h00} :
                      seq_result[7:0];

  // ==========================================================
  // Read mux; unmapped addresses read zero
  wire [7:0] ctrl_rd = {converter_enable_bit, delayed_tracking_bit,
                        conversion_complete_flag, busy, 1'b0,
                        trigger_select_field};
  wire [7:0] cfg_rd  = {sar_clock_divider, justify_select_bit,
                        eight_bit_mode_bit, gain_bit};
  wire [7:0] rd_mux  =
    (reg_addr == `SACC_ADDR_CTRL)  ? ctrl_rd :
    (reg_addr == `SACC_ADDR_CFG)   ? cfg_rd :
    (reg_addr == `SACC_ADDR_RESHI) ? result_high_byte :
    (reg_addr == `SACC_ADDR_RESLO) ? result_low_byte :
    8'h00;

  // Strobe to the analog core, one per SAR clock
  assign sar_clk_tick = sar_tick;

  // ==========================================================
  // Bit sequencer, aborted the moment the enable drops
  sacc_sar_seq u_seq (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .start      (seq_start),
    .abort      (~converter_enable_bit),
    .sar_tick   (sar_tick),
    .eight_bit  (eight_bit_mode_bit),
    .cmp_in     (cmp_in),
    .trial_code (sar_trial_code),
    .result     (seq_result),
    .done       (seq_done)
  );

  // ==========================================================
  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      sacc_pkg::SACC_IDLE: begin
        // Delay mode keeps tracking before conversion
        if (trig_fire) begin
          next_state = delayed_tracking_bit ? sacc_pkg::SACC_DELAY
                                            : sacc_pkg::SACC_CONV;
        end
      end
      sacc_pkg::SACC_DELAY: begin
        if (dly_done) begin
          next_state = sacc_pkg::SACC_CONV;
        end
      end
      sacc_pkg::SACC_CONV: begin
        if (seq_done) begin
          next_state = sacc_pkg::SACC_IDLE;
        end
      end
    endcase
    // Shutdown overrides everything
    if (!converter_enable_bit) begin
      next_state = sacc_pkg::SACC_IDLE;
    end
  end

  // ==========================================================
  // Tracking level; strobe mode without delay tracks on low
  always_comb begin
    next_track = 1'b0;
    if (converter_enable_bit && state != sacc_pkg::SACC_CONV) begin
      if (sel_ext) begin
        next_track = delayed_tracking_bit | ~strb_s2;
      end else begin
        next_track = 1'b1;
      end
    end
  end

  // ==========================================================
  // State, divider and delay counters
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state   <= sacc_pkg::SACC_IDLE;
      div_cnt <= 5'h00;
      dly_cnt <= 2'h0;
    end else begin
      state   <= next_state;
      // Divider restarts with each trigger so timing is fixed
      div_cnt <= (!run || sar_tick) ? 5'h00 : div_cnt + 5'h01;
      dly_cnt <= (state != sacc_pkg::SACC_DELAY) ? 2'h0 :
                 sar_tick ? dly_cnt + 2'h1 : dly_cnt;
    end
  end

  // ==========================================================
  // Strobe pin synchroniser and edge history
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      strb_s1 <= 1'b0;
      strb_s2 <= 1'b0;
      strb_s3 <= 1'b0;
    end else begin
      strb_s1 <= external_convert_strobe;
      strb_s2 <= strb_s1;
      strb_s3 <= strb_s2;
    end
  end

  // ==========================================================
  // Control and configuration registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {converter_enable_bit, delayed_tracking_bit} <= 2'h0;
      trigger_select_field <= `SACC_SEL_RST;
      {sar_clock_divider, justify_select_bit,
       eight_bit_mode_bit, gain_bit} <= `SACC_CFG_RST;
    end else begin
      if (wr_ctrl) begin
        converter_enable_bit <= reg_wdata[`SACC_CTRL_EN];
        delayed_tracking_bit <= reg_wdata[`SACC_CTRL_DTRK];
        trigger_select_field <=
          reg_wdata[`SACC_CTRL_SELHI:`SACC_CTRL_SELLO];
      end
      if (wr_cfg) begin
        {sar_clock_divider, justify_select_bit,
         eight_bit_mode_bit, gain_bit} <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // Completion flag; a finishing conversion beats a clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      conversion_complete_flag <= 1'b0;
    end else if (conv_ok) begin
      conversion_complete_flag <= 1'b1;
    end else if (wr_ctrl) begin
      conversion_complete_flag <= reg_wdata[`SACC_CTRL_DONE];
    end
  end

  // ==========================================================
  // Result bytes; written together with the flag
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      result_high_byte <= 8'h00;
      result_low_byte  <= 8'h00;
    end else if (conv_ok) begin
      result_high_byte <= fmt_hi;
      result_low_byte  <= fmt_lo;
    end else begin
      if (wr_reshi) begin
        result_high_byte <= reg_wdata;
      end
      if (wr_reslo) begin
        result_low_byte <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // Registered outputs and read data
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata    <= 8'h00;
      conv_irq     <= 1'b0;
      sar_power_on <= 1'b0;
      sar_track    <= 1'b0;
    end else begin
      reg_rdata    <= reg_rd ? rd_mux : 8'h00;
      conv_irq     <= conversion_complete_flag & irq_enable;
      sar_power_on <= converter_enable_bit;
      sar_track    <= next_track;
    end
  end

  // ==========================================================
  // Checking helpers: SAR clocks per conversion, tick gaps
  logic [3:0] chk_conv_ticks;  // Ticks since sequencer start
  logic [1:0] chk_dly_ticks;   // Ticks spent in delay
  logic [4:0] chk_gap;         // Cycles since last tick
  logic       chk_had_tick;    // A tick seen in this run
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      chk_conv_ticks <= 4'h0;
      chk_dly_ticks  <= 2'h0;
      chk_gap        <= 5'h00;
      chk_had_tick   <= 1'b0;
    end else begin
      chk_conv_ticks <= seq_start ? 4'h0 :
        (sar_tick && state == sacc_pkg::SACC_CONV) ?
        chk_conv_ticks + 4'h1 : chk_conv_ticks;
      chk_dly_ticks  <= (trig_fire) ? 2'h0 :
        (sar_tick && state == sacc_pkg::SACC_DELAY) ?
        chk_dly_ticks + 2'h1 : chk_dly_ticks;
      chk_gap        <= (!run || sar_tick) ? 5'h00 : chk_gap + 5'h01;
      chk_had_tick   <= run & (chk_had_tick | sar_tick);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  AST_SHUTDOWN: assert property (
    !converter_enable_bit |=> !busy && !sar_power_on && !sar_track)
    else $error("converter active while disabled");
  AST_RIGHT: assert property (
    conv_ok && !eight_bit_mode_bit && !justify_select_bit |=>
      result_high_byte[7:2] == 6'h00 &&
      {result_high_byte[1:0], result_low_byte} == $past(seq_result))
    else $error("right justified result wrong");
  AST_LEFT: assert property (
    conv_ok && !eight_bit_mode_bit && justify_select_bit |=>
      {result_high_byte, result_low_byte} ==
      {$past(seq_result), 6'h00})
    else $error("left justified result wrong");
  AST_EIGHT: assert property (
    conv_ok && eight_bit_mode_bit |=> result_low_byte == 8'h00 &&
      result_high_byte == $past(seq_result[9:2]))
    else $error("eight-bit result wrong");
  AST_LENGTH: assert property (
    seq_done && converter_enable_bit |-> chk_conv_ticks ==
      (eight_bit_mode_bit ? `SACC_CLKS_EIGHT : `SACC_CLKS_TEN))
    else $error("conversion length wrong");
  AST_DIVIDE: assert property (
    sar_tick && chk_had_tick |-> chk_gap == sar_clock_divider)
    else $error("SAR clock period wrong");
  AST_SW_START: assert property (
    sw_go && converter_enable_bit && idle |=> busy)
    else $error("software start ignored");
  AST_BUSY_HOLD: assert property (
    busy && converter_enable_bit && !seq_done |=> busy)
    else $error("busy dropped early");
  AST_FLAG: assert property (
    $fell(busy) && $past(converter_enable_bit) |->
      conversion_complete_flag ##1 (conv_irq == irq_enable))
    else $error("completion flag not set");
  AST_EXT_START: assert property (
    sel_ext && strb_rise && idle && converter_enable_bit &&
      !delayed_tracking_bit |=> state == sacc_pkg::SACC_CONV)
    else $error("strobe start missed");
  AST_TMR_SRC: assert property (
    trigger_select_field == `SACC_TRIG_TMR2 && tmr2_split &&
      !tmr2_lo_ovf && idle |=> idle)
    else $error("wrong timer byte started");
  AST_DELAY: assert property (
    dly_done |-> chk_dly_ticks == (`SACC_DLY_CLKS - 2'h1) ##1
      state == sacc_pkg::SACC_CONV)
    else $error("delay length wrong");
  AST_NO_DELAY: assert property (
    trig_fire && !delayed_tracking_bit |=>
      state == sacc_pkg::SACC_CONV && sar_trial_code == `SACC_CODE_START)
    else $error("conversion not immediate");
  AST_TRACK_INT: assert property (
    converter_enable_bit && idle && !sel_ext |=> sar_track)
    else $error("idle converter not tracking");
  AST_TRACK_EXT: assert property (
    converter_enable_bit && idle && sel_ext &&
      !delayed_tracking_bit && strb_s2 |=> !sar_track)
    else $error("tracking while strobe high");
  AST_RESERVED: assert property (
    trigger_select_field > `SACC_TRIG_TMR3 && idle |=> idle)
    else $error("reserved trigger started");

  COV_SW_CONV: cover property (sw_go ##[1:500] conv_ok);
  COV_DELAYED: cover property (dly_done ##[1:500] conv_ok);
  COV_EIGHT:   cover property (conv_ok && eight_bit_mode_bit);
  COV_ABORT:   cover property (busy && !converter_enable_bit);
endmodule

// ---- verif/sacc_core_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Analog side: input mux held as a fixed code, plus comparator
module sacc_core_model (
  input  wire logic       sar_power_on,
  input  wire logic [9:0] sar_trial_code,
  input  wire logic [9:0] analog_code,
  output logic            cmp_in
);
  // Shut down core answers low, so a dead converter yields zero
  assign cmp_in = sar_power_on && (analog_code >= sar_trial_code);
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
// ==========================================================
// Bench for the conversion control
module testbench;
  logic       clk_sys, arst_n, reg_wr, reg_rd, irq_enable, cmp_in, split;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [6:0] trg;          // t0,t1,t2lo,t2hi,t3lo,t3hi,strobe
  logic [9:0] analog_code, sar_trial_code;
  logic       conv_irq, sar_power_on, sar_track, sar_clk_tick;
  int         errors, checks_done, cycles, tnum, ticks;

  sacc_conv_ctrl sacc_conv_ctrl_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tmr0_ovf(trg[0]),
    .tmr1_ovf(trg[1]), .tmr2_lo_ovf(trg[2]), .tmr2_hi_ovf(trg[3]),
    .tmr2_split(split), .tmr3_lo_ovf(trg[4]), .tmr3_hi_ovf(trg[5]),
    .tmr3_split(split), .external_convert_strobe(trg[6]),
    .irq_enable(irq_enable), .cmp_in(cmp_in), .conv_irq(conv_irq),
    .sar_power_on(sar_power_on), .sar_track(sar_track),
    .sar_clk_tick(sar_clk_tick), .sar_trial_code(sar_trial_code));
  sacc_core_model sacc_core_model_i (.sar_power_on(sar_power_on),
    .sar_trial_code(sar_trial_code), .analog_code(analog_code),
    .cmp_in(cmp_in));

  // ==========================================================
  // Clock, and a hang guard well above the expected run
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    // SAR clock strobes seen by the analog core
    if (sar_clk_tick === 1'b1) ticks++;
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // ==========================================================
  // Access and compare tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // One-cycle trigger, then time for the strobe synchroniser
  task automatic pulse(input int t);
    @(posedge clk_sys);
    trg[t] <= 1'b1;
    @(posedge clk_sys);
    trg[t] <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  // Trigger index 7 means a software start
  task automatic conv(input logic [7:0] cfg, input logic [7:0] ctl,
                      input int t, input logic s, input logic [9:0] code);
    int n, t0;
    logic [7:0] eh, el, nt;
    // Keep triggers at least 2 us apart
    repeat (250) @(posedge clk_sys);
    analog_code <= code;
    split <= s;
    wr(8'hbc, cfg);
    wr(8'he8, ctl);
    t0 = ticks;
    if (t == 7) wr(8'he8, ctl | 8'h10);
    else pulse(t);
    rd(8'he8); check(rv & 8'h30, 8'h10);
    n = 0;
    // Poll the flag, never the busy bit
    while (rv[5] !== 1'b1 && n < 100) begin
      rd(8'he8);
      n++;
    end
    check(rv & 8'h30, 8'h20);
    check({7'h0, conv_irq}, {7'h0, irq_enable});
    check({7'h0, sar_track}, 8'h01);
    // SAR clocks: 13 or 11, plus 3 in delayed tracking
    nt = cfg[1] ? 8'h0b : 8'h0d;
    if (ctl[6]) nt = nt + 8'h03;
    check(8'(ticks - t0), nt);
    if (cfg[1]) begin
      eh = code[9:2]; el = 8'h00;
    end else if (cfg[2]) begin
      eh = code[9:2]; el = {code[1:0], 6'h00};
    end else begin
      eh = {6'h00, code[9:8]}; el = code[7:0];
    end
    rd(8'hbe); check(rv, eh);
    rd(8'hbd); check(rv, el);
    tnum++;
    $display("test %0d done", tnum);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 8'h00; trg = 7'h00; split = 1'b0; irq_enable = 1'b1;
    analog_code = 10'h000;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(8'hbc); check(rv, 8'hf9);
    rd(8'he8); check(rv, 8'h00);
    rd(8'hbe); check(rv, 8'h00);
    rd(8'h00); check(rv, 8'h00);
    // Busy write while disabled must not start anything
    wr(8'he8, 8'h10); rd(8'he8); check(rv, 8'h00);
    check({7'h0, sar_power_on}, 8'h00);
    conv(8'h01, 8'h80, 7, 1'b0, 10'h3ff);
    conv(8'h05, 8'hc0, 7, 1'b0, 10'h200);
    conv(8'h0b, 8'h81, 0, 1'b0, 10'h2a5);
    conv(8'h01, 8'h82, 2, 1'b1, 10'h100);
    // Split timer: high byte overflow is not the trigger
    wr(8'he8, 8'h82); pulse(3); rd(8'he8); check(rv, 8'h82);
    conv(8'h05, 8'h82, 3, 1'b0, 10'h155);
    // Interrupt masked: flag still sets, request stays low
    irq_enable <= 1'b0;
    conv(8'h01, 8'h83, 1, 1'b0, 10'h000);
    irq_enable <= 1'b1;
    conv(8'h01, 8'hc4, 6, 1'b0, 10'h0aa);
    conv(8'h01, 8'h84, 6, 1'b0, 10'h2ff);
    conv(8'h07, 8'h85, 4, 1'b1, 10'h3ff);
    conv(8'h0d, 8'h85, 5, 1'b0, 10'h1c3);
    // Reserved select code never starts
    wr(8'he8, 8'h86); pulse(0); rd(8'he8); check(rv, 8'h86);
    wrap_up();
  end
endmodule
